// >>> hdl/bse_speed_loop_engine.v
// brushless speed loop engine: pwm master, commuted phases, quad decoder, speed regulator
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "bse_map.vh"
module bse_speed_loop_engine #(
  parameter HALF_PERIOD = `BSE_PWM_CYCLES / 2,
  parameter REG_DIV     = 40,
  parameter LEAD_TIME   = 200,
  parameter REG_OFFSET  = 600
) (
  input  wire        CLK_SYS_I,   // 125 MHz clock
  input  wire        RST_N_I,     // async reset, low
  input  wire        SRST_I,      // synchronous engine reset
  input  wire [3:0]  ADDR_I,      // register index
  input  wire [31:0] WDATA_I,     // write data
  input  wire        WR_I,        // write strobe
  input  wire        RD_I,        // read strobe
  output reg  [31:0] RDATA_O,     // read data
  input  wire        ENC_A_I,     // encoder phase a
  input  wire        ENC_B_I,     // encoder phase b
  input  wire        ENC_IDX_I,   // encoder index
  output reg  [2:0]  PH_BASE_O,   // base channels
  output reg  [2:0]  PH_COMPL_O,  // complementary channels
  output reg         MASTER_ACT_O,// master activity pin
  output reg         REG_ACT_O    // regulator activity pin
);
  localparam S_IDLE = 2'd0, S_REG = 2'd1, S_ACCEPT = 2'd2, S_UPDATE = 2'd3;
  reg  [12:0] cnt_reg;
  reg         dn_reg;
  reg  [5:0]  div_reg;
  reg  [31:0] time_reg;
  reg  [1:0]  svc_reg;
  reg  [3:0]  svc_cnt_reg;
  reg         reg_pend_reg;
  reg         upd_pend_reg;
  reg         volt_new_reg;
  reg         duty_pend_reg;
  reg  [23:0] speed_req_reg, kp_reg, ki_reg, ramp_step_reg, ramp_reg;
  reg  [1:0]  ctrl_reg;
  reg  [23:0] pos_reg, delta_reg, revs_reg, speed_reg, volt_reg, volt_out_reg;
  reg  [31:0] edge_time_reg, prev_edge_reg;
  reg  [31:0] integ_reg;
  reg         dir_reg;
  reg  [2:0]  a_sync, b_sync, i_sync;
  reg         a_st, b_st, i_st;
  reg  [7:0]  base_st [0:2];
  reg  [7:0]  comp_st [0:2];
  reg  [2:0]  neg_reg;
  reg  [12:0] duty_reg [0:2];
  wire [12:0] cnt_next = dn_reg ? cnt_reg - 13'd1 : cnt_reg + 13'd1;
  wire        period_end = dn_reg && (cnt_reg == 13'd1);
  ////////////////////////////////////////////////////////////////////////
  // encoder synchronisers: change counts once second and third agree
  always @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      a_sync <= 3'h0;
      b_sync <= 3'h0;
      i_sync <= 3'h0;
      a_st   <= 1'b0;
      b_st   <= 1'b0;
      i_st   <= 1'b0;
    end
    else
    begin
      a_sync <= {a_sync[1:0], ENC_A_I};
      b_sync <= {b_sync[1:0], ENC_B_I};
      i_sync <= {i_sync[1:0], ENC_IDX_I};
      if (a_sync[1] == a_sync[2]) a_st <= a_sync[2];
      if (b_sync[1] == b_sync[2]) b_st <= b_sync[2];
      if (i_sync[1] == i_sync[2]) i_st <= i_sync[2];
    end
  end
  wire a_new = (a_sync[1] == a_sync[2]) ? a_sync[2] : a_st;
  wire b_new = (b_sync[1] == b_sync[2]) ? b_sync[2] : b_st;
  wire i_new = (i_sync[1] == i_sync[2]) ? i_sync[2] : i_st;
  wire qstep = (a_new ^ a_st) | (b_new ^ b_st);
  wire qfwd  = (a_new ^ a_st) ? (a_new ^ b_st) : ~(b_new ^ a_st);
  ////////////////////////////////////////////////////////////////////////
  // speed computation terms
  wire signed [47:0] pos_delta = {{24{delta_reg[23]}}, delta_reg};
  wire        [31:0] t_diff    = edge_time_reg - prev_edge_reg;
  wire signed [47:0] spd_raw   = (t_diff == 32'h0) ? 48'sh0 : (pos_delta <<< 20) / $signed({16'h0, t_diff});
  wire signed [23:0] spd_sat   = (spd_raw > 48'sh7fffff) ? 24'sh7fffff :
                                 (spd_raw < -48'sh7fffff) ? -24'sh7fffff : spd_raw[23:0];
  wire signed [24:0] err       = $signed({ramp_reg[23], ramp_reg}) - $signed({speed_reg[23], speed_reg});
  wire signed [49:0] p_term    = err * $signed(kp_reg);
  wire signed [49:0] i_term    = err * $signed(ki_reg);
  wire signed [31:0] integ_nx  = $signed(integ_reg) + $signed(i_term[46:15]);
  wire signed [31:0] pi_sum    = integ_nx + $signed(p_term[46:15]);
  wire signed [23:0] pi_sat    = (pi_sum > 32'sh7fffff) ? 24'sh7fffff :
                                 (pi_sum < -32'sh7fffff) ? -24'sh7fffff : pi_sum[23:0];
  wire signed [24:0] r_diff    = $signed({speed_req_reg[23], speed_req_reg}) - $signed({ramp_reg[23], ramp_reg});
  wire signed [24:0] r_step    = $signed({1'b0, ramp_step_reg});
  wire [23:0] ramp_nx = (r_diff > r_step) ? ramp_reg + ramp_step_reg :
                        (r_diff < -r_step) ? ramp_reg - ramp_step_reg : speed_req_reg;
  wire [23:0] vmag    = volt_out_reg[23] ? 24'h0 : volt_out_reg;
  wire [36:0] duty_p  = vmag * HALF_PERIOD;
  ////////////////////////////////////////////////////////////////////////
  // pwm time base, decoder, services
  integer k;
  always @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cnt_reg <= 13'h0; dn_reg <= 1'b0; div_reg <= 6'h0; time_reg <= 32'h0;
      svc_reg <= S_IDLE; svc_cnt_reg <= 4'h0; reg_pend_reg <= 1'b0; upd_pend_reg <= 1'b0;
      volt_new_reg <= 1'b0; duty_pend_reg <= 1'b0; ramp_reg <= 24'h0; integ_reg <= 32'h0;
      pos_reg <= 24'h0; delta_reg <= 24'h0; revs_reg <= 24'h0; dir_reg <= 1'b0;
      speed_reg <= 24'h0; volt_reg <= 24'h0; volt_out_reg <= 24'h0;
      edge_time_reg <= 32'h0; prev_edge_reg <= 32'h0; neg_reg <= 3'h0;
      for (k = 0; k < 3; k = k + 1)
      begin
        duty_reg[k] <= 13'h0;
      end
    end
    else if (SRST_I)
    begin
      pos_reg <= 24'h0; revs_reg <= 24'h0; delta_reg <= 24'h0; ramp_reg <= 24'h0;
      integ_reg <= 32'h0; svc_reg <= S_IDLE; reg_pend_reg <= 1'b0; upd_pend_reg <= 1'b0;
    end
    else
    begin
      time_reg <= time_reg + 32'h1;
      cnt_reg <= cnt_next;
      if (!dn_reg && cnt_next == HALF_PERIOD[12:0]) dn_reg <= 1'b1;
      if (period_end)
      begin
        dn_reg  <= 1'b0;
        div_reg <= (div_reg == REG_DIV - 1) ? 6'h0 : div_reg + 6'h1;
      end
      if (qstep)
      begin
        pos_reg <= qfwd ? pos_reg + 24'h1 : pos_reg - 24'h1;
        dir_reg <= qfwd;
        edge_time_reg <= time_reg;
      end
      if (i_new && !i_st) revs_reg <= dir_reg ? revs_reg + 24'h1 : revs_reg - 24'h1;
      if (dn_reg && cnt_reg == LEAD_TIME + REG_OFFSET && div_reg == REG_DIV - 1 && ctrl_reg[0])
        reg_pend_reg <= 1'b1;
      if (dn_reg && cnt_reg == LEAD_TIME && ctrl_reg[0])
        upd_pend_reg <= 1'b1;
      case (svc_reg)
        S_IDLE:
        begin
          svc_cnt_reg <= 4'h0;
          if (reg_pend_reg) begin reg_pend_reg <= 1'b0; svc_reg <= S_REG; end
          else if (upd_pend_reg) begin upd_pend_reg <= 1'b0; svc_reg <= S_UPDATE; end
        end
        S_REG:
        begin
          svc_cnt_reg <= svc_cnt_reg + 4'h1;
          if (svc_cnt_reg == 4'h0)
          begin
            speed_reg <= spd_sat;
            prev_edge_reg <= edge_time_reg;
            delta_reg <= qstep ? (qfwd ? 24'h1 : 24'hffffff) : 24'h0;
            ramp_reg <= ramp_nx;
          end
          if (svc_cnt_reg == 4'h1)
          begin
            integ_reg <= integ_nx;
            volt_reg <= ctrl_reg[1] ? pi_sat : ramp_reg;
            svc_reg <= S_ACCEPT;
          end
        end
        S_ACCEPT:
        begin
          volt_out_reg <= volt_reg;
          volt_new_reg <= 1'b1;
          svc_reg <= S_IDLE;
        end
        default:
        begin
          svc_cnt_reg <= svc_cnt_reg + 4'h1;
          if (svc_cnt_reg == 4'h0 && volt_new_reg) duty_pend_reg <= 1'b1;
          if (svc_cnt_reg == 4'h3 || (svc_cnt_reg == 4'h0 && !volt_new_reg))
          begin
            if (duty_pend_reg)
            begin
              for (k = 0; k < 3; k = k + 1)
              begin
                duty_reg[k] <= duty_p[35:23];
              end
              volt_new_reg  <= 1'b0;
              duty_pend_reg <= 1'b0;
            end
            svc_reg <= S_IDLE;
          end
        end
      endcase
      // only the capture cycle restarts the delta; steps in every other cycle accumulate
      if (!(svc_reg == S_REG && svc_cnt_reg == 4'h0) && qstep)
        delta_reg <= qfwd ? delta_reg + 24'h1 : delta_reg - 24'h1;
      for (k = 0; k < 3; k = k + 1)
      begin
        neg_reg[k] <= base_st[k] == `BSE_ST_ON_LOW;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // commuted phase outputs and activity pins
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_phase
      wire act = duty_reg[g] > cnt_reg;
      always @(posedge CLK_SYS_I or negedge RST_N_I)
      begin
        if (!RST_N_I)
        begin
          PH_BASE_O[g]  <= 1'b0;
          PH_COMPL_O[g] <= 1'b1;
        end
        else if (SRST_I || !ctrl_reg[0])
        begin
          PH_BASE_O[g]  <= 1'b0;
          PH_COMPL_O[g] <= 1'b1;
        end
        else
        begin
          // each channel's polarity follows its own state: on-high drives act, on-low drives ~act
          case (base_st[g])
            `BSE_ST_ON_HIGH: PH_BASE_O[g] <= act;
            `BSE_ST_ON_LOW:  PH_BASE_O[g] <= ~act;
            `BSE_ST_OFF_HIGH: PH_BASE_O[g] <= 1'b1;
            default:         PH_BASE_O[g] <= 1'b0;
          endcase
          case (comp_st[g])
            `BSE_ST_ON_HIGH: PH_COMPL_O[g] <= act;
            `BSE_ST_ON_LOW:  PH_COMPL_O[g] <= ~act;
            `BSE_ST_OFF_HIGH: PH_COMPL_O[g] <= 1'b1;
            default:         PH_COMPL_O[g] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate
  always @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      MASTER_ACT_O <= 1'b0;
      REG_ACT_O    <= 1'b0;
    end
    else
    begin
      MASTER_ACT_O <= (svc_reg == S_ACCEPT) || (svc_reg == S_UPDATE);
      REG_ACT_O    <= svc_reg == S_REG;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // register port
  always @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      speed_req_reg <= 24'h0; kp_reg <= 24'h0; ki_reg <= 24'h0;
      ramp_step_reg <= 24'h0; ctrl_reg <= 2'h0;
      for (k = 0; k < 3; k = k + 1)
      begin
        base_st[k] <= `BSE_ST_OFF_LOW;
        comp_st[k] <= `BSE_ST_OFF_LOW;
      end
    end
    else if (WR_I)
    begin
      case (ADDR_I)
        `BSE_REG_SPEED_REQ: speed_req_reg <= WDATA_I[23:0];
        `BSE_REG_KP:        kp_reg <= WDATA_I[23:0];
        `BSE_REG_KI:        ki_reg <= WDATA_I[23:0];
        `BSE_REG_RAMP_STEP: ramp_step_reg <= WDATA_I[23:0];
        `BSE_REG_CTRL:      ctrl_reg <= WDATA_I[1:0];
        `BSE_REG_COMMUTATE:
        begin
          if (WDATA_I[7:0] < 8'h3)
          begin
            base_st[WDATA_I[1:0]] <= WDATA_I[15:8];
            comp_st[WDATA_I[1:0]] <= WDATA_I[23:16];
          end
        end
        default: ;
      endcase
    end
  end
  always @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      RDATA_O <= 32'h0;
    else if (RD_I)
    begin
      case (ADDR_I)
        `BSE_REG_SPEED_REQ: RDATA_O <= {8'h0, speed_req_reg};
        `BSE_REG_KP:        RDATA_O <= {8'h0, kp_reg};
        `BSE_REG_KI:        RDATA_O <= {8'h0, ki_reg};
        `BSE_REG_RAMP_STEP: RDATA_O <= {8'h0, ramp_step_reg};
        `BSE_REG_CTRL:      RDATA_O <= {30'h0, ctrl_reg};
        `BSE_REG_POSITION:  RDATA_O <= {8'h0, pos_reg};
        `BSE_REG_REVS:      RDATA_O <= {8'h0, revs_reg};
        `BSE_REG_SPEED:     RDATA_O <= {8'h0, speed_reg};
        `BSE_REG_VOLTAGE:   RDATA_O <= {8'h0, volt_out_reg};
        `BSE_REG_STATUS:    RDATA_O <= {29'h0, neg_reg[0], dir_reg, volt_new_reg};
        default:            RDATA_O <= 32'h0;
      endcase
    end
  end
endmodule // bse_speed_loop_engine

// >>> hdl/bse_map.vh
// constants for the brushless speed loop engine
`ifndef BSE_MAP_VH
`define BSE_MAP_VH
`define BSE_CLK_HZ        125000000
`define BSE_PWM_PERIOD_NS 50000
`define BSE_PWM_CYCLES    (`BSE_PWM_PERIOD_NS / 8)
`define BSE_REG_SPEED_REQ 4'h0
`define BSE_REG_KP        4'h1
`define BSE_REG_KI        4'h2
`define BSE_REG_RAMP_STEP 4'h3
`define BSE_REG_COMMUTATE 4'h4
`define BSE_REG_CTRL      4'h5
`define BSE_REG_POSITION  4'h6
`define BSE_REG_REVS      4'h7
`define BSE_REG_SPEED     4'h8
`define BSE_REG_VOLTAGE   4'h9
`define BSE_REG_STATUS    4'ha
`define BSE_CTRL_EN_BIT   0
`define BSE_CTRL_CLOSED_BIT 1
`define BSE_ST_ON_HIGH    8'h00
`define BSE_ST_ON_LOW     8'h01
`define BSE_ST_OFF_LOW    8'h02
`define BSE_ST_OFF_HIGH   8'h03
`define BSE_OPT_DUTY_POS  8'h00
`define BSE_OPT_DUTY_NEG  8'h01
`endif

// >>> sim/bse_chk.sv
// port checker for the brushless speed loop engine
`timescale 1ns/10ps
module bse_chk #(
  parameter HALF_PERIOD = 100,
  parameter REG_DIV     = 40
) (
  input wire        CLK_SYS_I,    // clock
  input wire        RST_N_I,      // async reset, low
  input wire        SRST_I,       // sync engine reset
  input wire [3:0]  ADDR_I,       // register index
  input wire [31:0] WDATA_I,      // write data
  input wire        WR_I,         // write strobe
  input wire        RD_I,         // read strobe
  input wire [31:0] RDATA_O,      // read data
  input wire [2:0]  PH_BASE_O,    // base pins
  input wire [2:0]  PH_COMPL_O,   // complement pins
  input wire        MASTER_ACT_O, // master activity
  input wire        REG_ACT_O     // regulator activity
);
  localparam int PER = 2 * HALF_PERIOD;
  localparam int RLO = (REG_DIV - 1) * PER;
  localparam int RHI = (REG_DIV + 1) * PER;
  reg        en_reg;
  reg        seen_reg;
  reg [31:0] gap_reg;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I || SRST_I);
  ////////////////////////////////////////////////////////////////////////////////
  // enable as last written, and cycles since the last regulator run began
  always @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      en_reg   <= 1'b0;
      seen_reg <= 1'b0;
      gap_reg  <= 32'h0;
    end
    else
    begin
      if (WR_I && ADDR_I == 4'h5)
        en_reg <= WDATA_I[0];
      gap_reg  <= $rose(REG_ACT_O) ? 32'h1 : gap_reg + 32'h1;
      seen_reg <= (SRST_I || !en_reg) ? 1'b0 : (seen_reg | $rose(REG_ACT_O));
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_excl;
    !(MASTER_ACT_O && REG_ACT_O);
  endproperty
  a_excl: assert property (p_excl) else $error("master and regulator active together");
  property p_follow;
    $fell(REG_ACT_O) && !$past(SRST_I) |-> ##[0:4] MASTER_ACT_O;
  endproperty
  a_follow: assert property (p_follow) else $error("no master service after regulator");
  property p_period;
    en_reg && $rose(MASTER_ACT_O) |-> ##[1:PER] $rose(MASTER_ACT_O);
  endproperty
  a_period: assert property (p_period) else $error("master update missing in a period");
  property p_rate;
    $rose(REG_ACT_O) && seen_reg |-> gap_reg >= RLO && gap_reg <= RHI;
  endproperty
  a_rate: assert property (p_rate) else $error("regulator run spacing wrong");
  property p_reg_width;
    $rose(REG_ACT_O) |-> ##[1:2] !REG_ACT_O;
  endproperty
  a_reg_width: assert property (p_reg_width) else $error("regulator pin stuck high");
  property p_m_width;
    $rose(MASTER_ACT_O) |-> ##[1:4] !MASTER_ACT_O;
  endproperty
  a_m_width: assert property (p_m_width) else $error("master pin stuck high");
  property p_srst;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      SRST_I |=> PH_BASE_O == 3'h0 && PH_COMPL_O == 3'h7;
  endproperty
  a_srst: assert property (p_srst) else $error("phases not off after engine reset");
  property p_unmapped;
    RD_I && ADDR_I > 4'ha |=> RDATA_O == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  c_run: cover property ($fell(REG_ACT_O));
  c_srst: cover property (SRST_I);
  c_pwm: cover property ($rose(PH_BASE_O[0]));
endmodule // bse_chk
bind bse_speed_loop_engine bse_chk #(.HALF_PERIOD(HALF_PERIOD), .REG_DIV(REG_DIV)) chk_u (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PH_BASE_O(PH_BASE_O), .PH_COMPL_O(PH_COMPL_O),
  .MASTER_ACT_O(MASTER_ACT_O), .REG_ACT_O(REG_ACT_O));

// >>> sim/bse_enc_model.sv
// shaft encoder model: quadrature and index levels
`timescale 1ns/10ps
module bse_enc_model (
  input  wire clk_i,  // clock
  output reg  a_o,    // phase a
  output reg  b_o,    // phase b
  output reg  idx_o   // index pulse
);
  reg [1:0] q_reg = 2'h0;
  initial
  begin
    a_o   = 1'b0;
    b_o   = 1'b0;
    idx_o = 1'b0;
  end
  // one gray step per count, a leads b when going forward
  task move(input integer n, input bit fwd, input integer gap);
    integer i;
    for (i = 0; i < n; i++)
    begin
      repeat (gap) @(posedge clk_i);
      q_reg = fwd ? q_reg + 2'h1 : q_reg - 2'h1;
      a_o  <= q_reg[0] ^ q_reg[1];
      b_o  <= q_reg[1];
    end
  endtask
  // once-per-revolution pulse while the shaft stands
  task index(input integer len);
    @(posedge clk_i);
    idx_o <= 1'b1;
    repeat (len) @(posedge clk_i);
    idx_o <= 1'b0;
  endtask
endmodule // bse_enc_model

// >>> sim/tb.sv
// testbench for the brushless speed loop engine
`timescale 1ns/10ps
module tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         srst = 1'b0;
  reg  [3:0]  addr = 4'h0;
  reg  [31:0] wdata = 32'h0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  wire [31:0] rdata;
  wire        enc_a, enc_b, enc_idx, m_act, r_act;
  wire [2:0]  ph_b, ph_c;
  integer     err_total = 0;
  integer     total_checks = 0;
  integer     k, n;
  reg  [31:0] d, s;
  always #4 clk = ~clk;
  localparam HALF_CYC = 100;
  localparam RUN_DIV  = 4;
  localparam LEAD_CYC = 10;
  localparam OFFS_CYC = 20;
  bse_speed_loop_engine #(.HALF_PERIOD(HALF_CYC), .REG_DIV(RUN_DIV), .LEAD_TIME(LEAD_CYC),
    .REG_OFFSET(OFFS_CYC)) dut_u (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .ENC_A_I(enc_a), .ENC_B_I(enc_b), .ENC_IDX_I(enc_idx),
    .PH_BASE_O(ph_b), .PH_COMPL_O(ph_c), .MASTER_ACT_O(m_act), .REG_ACT_O(r_act));
  bse_enc_model enc_u (.clk_i(clk), .a_o(enc_a), .b_o(enc_b), .idx_o(enc_idx));
  ////////////////////////////////////////////////////////////////////////////////
  task cmp_word(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmp_pin(input [2:0] got, input [2:0] exp);
    cmp_word({29'h0, got}, {29'h0, exp});
  endtask
  task wr_reg(input [3:0] a, input [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task rd_reg(input [3:0] a, output [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask
  // commutation word, then two pwm periods for the phases to settle
  task commute(input [31:0] w);
    wr_reg(4'h4, w);
    repeat (400) @(posedge clk);
    #1;
  endtask
  task wait_run;
    n = 0;
    while (r_act !== 1'b1 && n < 2000) begin @(posedge clk); #1; n++; end
    while (r_act !== 1'b0 && n < 2000) begin @(posedge clk); #1; n++; end
    cmp_word(n < 2000, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    cmp_pin(ph_b, 3'h0);
    cmp_pin(ph_c, 3'h7);
    rd_reg(4'h6, d);
    cmp_word(d, 32'h0);
    wr_reg(4'hf, 32'hffffffff);
    rd_reg(4'hf, d);
    cmp_word(d, 32'h0);
  endtask
  task t_encoder;
    enc_u.move(8, 1, 8);
    repeat (10) @(posedge clk);
    rd_reg(4'h6, d);
    cmp_word(d, 32'h8);
    rd_reg(4'ha, s);
    enc_u.index(6);
    repeat (10) @(posedge clk);
    rd_reg(4'h7, d);
    cmp_word(d, 32'h1);
    enc_u.move(12, 0, 3);
    repeat (10) @(posedge clk);
    rd_reg(4'h6, d);
    cmp_word(d, 32'h00fffffc);
    rd_reg(4'ha, d);
    cmp_pin({2'h0, d[1] ^ s[1]}, 3'h1);
    enc_u.index(6);
    repeat (10) @(posedge clk);
    rd_reg(4'h7, d);
    cmp_word(d, 32'h0);
  endtask
  task t_commute;
    commute(32'h00020300);
    cmp_pin(ph_b, 3'h1);
    cmp_pin(ph_c, 3'h0);
    commute(32'h00000100);
    rd_reg(4'ha, d);
    cmp_pin({2'h0, d[2]}, 3'h1);
    commute(32'h00000203);
    rd_reg(4'ha, d);
    cmp_pin({2'h0, d[2]}, 3'h1);
  endtask
  task t_ramp;
    wr_reg(4'h0, 32'h00300000);
    wr_reg(4'h3, 32'h00100000);
    commute(32'h00010000);
    wr_reg(4'h5, 32'h1);
    for (k = 1; k <= 4; k++)
    begin
      wait_run;
      repeat (20) @(posedge clk);
      rd_reg(4'h9, d);
      cmp_word(d, (k > 3 ? 3 : k) * 32'h00100000);
    end
    // closed loop, proportional gain 2.0, shaft at rest
    wr_reg(4'h1, 32'h00010000);
    wr_reg(4'h5, 32'h3);
    wait_run;
    repeat (20) @(posedge clk);
    rd_reg(4'h9, d);
    cmp_word(d, 32'h00600000);
    rd_reg(4'h8, d);
    cmp_word(d, 32'h0);
    n = 0;
    d = 0;
    s[0] = ph_b[0];
    repeat (600)
    begin
      @(posedge clk);
      #1;
      if (ph_b[0] === 1'b1 && s[0] !== 1'b1) n++;
      if (ph_c[0] !== ~ph_b[0]) d++;
      s[0] = ph_b[0];
    end
    cmp_word(n >= 2 && n <= 4, 1);
    cmp_word(d, 32'h0);
  endtask
  task t_srst;
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    cmp_pin(ph_b, 3'h0);
    cmp_pin(ph_c, 3'h7);
    rd_reg(4'h6, d);
    cmp_word(d, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_total++;
    give_verdict;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_encoder;
    t_ramp;
    t_commute;
    t_srst;
    give_verdict;
  end
endmodule // tb
